/* core/hms_pkg.sv */
`include "hms_regs.svh"
package hms_pkg;
   typedef enum logic [2:0] {
      HMS_IDLE,
      HMS_REV_HIGH,
      HMS_REV_LOW,
      HMS_FWD_HIGH,
      HMS_FWD_LOW,
      HMS_DONE
   } hms_state_t;

   typedef enum logic [1:0] {
      HMS_CASE_NONE,
      HMS_CASE_CLEAR,
      HMS_CASE_ON_SWITCH,
      HMS_CASE_LIMIT
   } hms_case_t;

   typedef struct packed {
      logic                        moving;
      logic                        reverse;
      logic                        high;
      logic [`HMS_SPEED_W-1:0]     speed;
   } hms_cmd_t;
endpackage

/* core/hms_regs.svh */
`ifndef HMS_REGS_SVH
`define HMS_REGS_SVH
`define HMS_SPEED_W      16
`define HMS_DEB_W        4
`define HMS_DEB_TIME_NS  400
`define HMS_CLK_NS       40
`define HMS_DEB_CYCLES   ((`HMS_DEB_TIME_NS + `HMS_CLK_NS - 1) / `HMS_CLK_NS)
`define HMS_SPEED_RST    16'h0000
`endif

/* core/hms_sequencer.sv */
// Notes on behaviour
// - At start pick one of three cases from switch and later reverse limit.
// - Start with switch inactive: run reverse at high homing speed.
// - Reverse high: switch rising edge drops to reverse low speed.
// - Reverse low: switch falling edge turns to forward low speed.
// - Forward low: next switch rising edge stops axis, homing done.
// - Start with switch active: reverse low speed at once, no high phase.
// - Switch-active case: switch transition turns to forward low speed.
// - Switch-active case: rising edge during forward low stops the axis.
// - Reverse limit during reverse high before any edge: forward high speed.
// - After limit: rising edge gives forward low, next rising edge stops.
`timescale 1ns/1ps
`include "hms_regs.svh"
module hms_sequencer
   import hms_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Control
   input  wire logic                    start,
   input  wire logic                    abort,
   input  wire logic [`HMS_SPEED_W-1:0] high_speed,
   input  wire logic [`HMS_SPEED_W-1:0] low_speed,
   // Sensors
   input  wire logic                    origin_sw,
   input  wire logic                    rev_limit,
   // Command and status
   output hms_cmd_t                     cmd,
   output hms_case_t                    home_case,
   output logic                         busy,
   output logic                         done
);
   localparam logic [`HMS_DEB_W-1:0] DEB_MAX = `HMS_DEB_W'(`HMS_DEB_CYCLES);

   hms_state_t           state;
   hms_state_t           next_state;
   logic                 sw_meta;
   logic                 sw_sync;
   logic                 lim_meta;
   logic                 lim_sync;
   logic                 sw_deb;
   logic                 sw_prev;
   logic [`HMS_DEB_W-1:0] deb_cnt;
   logic                 sw_rise;
   logic                 sw_fall;
   logic                 sw_edge;

   // Two-stage synchronisers; first stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sw_meta  <= 1'b0;
         sw_sync  <= 1'b0;
         lim_meta <= 1'b0;
         lim_sync <= 1'b0;
      end
      else
      begin
         sw_meta  <= origin_sw;
         sw_sync  <= sw_meta;
         lim_meta <= rev_limit;
         lim_sync <= lim_meta;
      end
   end

   // Debounce: level must hold a fixed count before it is accepted
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         deb_cnt <= '0;
         sw_deb  <= 1'b0;
      end
      else if (sw_sync == sw_deb)
         deb_cnt <= '0;
      else if (deb_cnt == DEB_MAX - 1'b1)
      begin
         deb_cnt <= '0;
         sw_deb  <= sw_sync;
      end
      else
         deb_cnt <= deb_cnt + 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sw_prev <= 1'b0;
      else
         sw_prev <= sw_deb;
   end

   assign sw_rise = sw_deb & ~sw_prev;
   assign sw_fall = ~sw_deb & sw_prev;
   assign sw_edge = sw_rise | sw_fall;

   always_comb
   begin
      next_state = state;
      case (state)
         HMS_IDLE:
            if (start)
               next_state = sw_deb ? HMS_REV_LOW : HMS_REV_HIGH;
         HMS_REV_HIGH:
            if (sw_rise)
               next_state = HMS_REV_LOW;
            else if (lim_sync)
               next_state = HMS_FWD_HIGH;
         HMS_REV_LOW:
            if (home_case == HMS_CASE_ON_SWITCH ? sw_edge : sw_fall)
               next_state = HMS_FWD_LOW;
         HMS_FWD_HIGH:
            if (sw_rise)
               next_state = HMS_FWD_LOW;
         HMS_FWD_LOW:
            if (sw_rise)
               next_state = HMS_DONE;
         HMS_DONE:
            if (start)
               next_state = sw_deb ? HMS_REV_LOW : HMS_REV_HIGH;
         default:
            next_state = HMS_IDLE;
      endcase
      // Abort wins so the axis can always be halted
      if (abort)
         next_state = HMS_IDLE;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= HMS_IDLE;
      else
         state <= next_state;
   end

   // Case record; limit case only known once the limit is met
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         home_case <= HMS_CASE_NONE;
      else if (abort)
         home_case <= HMS_CASE_NONE;
      else if ((state == HMS_IDLE || state == HMS_DONE) && start)
         home_case <= sw_deb ? HMS_CASE_ON_SWITCH : HMS_CASE_CLEAR;
      else if (state == HMS_REV_HIGH && next_state == HMS_FWD_HIGH)
         home_case <= HMS_CASE_LIMIT;
   end

   // Registered command from the next state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd  <= '{moving: 1'b0, reverse: 1'b0, high: 1'b0, speed: `HMS_SPEED_RST};
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         cmd.moving  <= next_state inside {HMS_REV_HIGH, HMS_REV_LOW, HMS_FWD_HIGH, HMS_FWD_LOW};
         cmd.reverse <= next_state inside {HMS_REV_HIGH, HMS_REV_LOW};
         cmd.high    <= next_state inside {HMS_REV_HIGH, HMS_FWD_HIGH};
         case (next_state)
            HMS_REV_HIGH, HMS_FWD_HIGH: cmd.speed <= high_speed;
            HMS_REV_LOW, HMS_FWD_LOW:   cmd.speed <= low_speed;
            default:                    cmd.speed <= `HMS_SPEED_RST;
         endcase
         busy <= next_state inside {HMS_REV_HIGH, HMS_REV_LOW, HMS_FWD_HIGH, HMS_FWD_LOW};
         done <= next_state == HMS_DONE;
      end
   end

   a_start_high: assert property (@(posedge clk) disable iff (rst)
      state inside {HMS_IDLE, HMS_DONE} && start && !abort && !sw_deb |=> cmd.moving && cmd.reverse && cmd.high)
      else $error("start with switch clear did not run reverse high");
   a_start_low: assert property (@(posedge clk) disable iff (rst)
      state inside {HMS_IDLE, HMS_DONE} && start && !abort && sw_deb |=> cmd.moving && cmd.reverse && !cmd.high)
      else $error("start on switch did not run reverse low");
   a_rise_slows: assert property (@(posedge clk) disable iff (rst)
      state == HMS_REV_HIGH && sw_rise && !abort |=> state == HMS_REV_LOW && cmd.speed == $past(low_speed))
      else $error("rising edge in reverse high did not slow");
   a_fall_turns: assert property (@(posedge clk) disable iff (rst)
      state == HMS_REV_LOW && sw_fall && !abort |=> state == HMS_FWD_LOW && !cmd.reverse)
      else $error("falling edge in reverse low did not turn forward");
   a_edge_case2: assert property (@(posedge clk) disable iff (rst)
      state == HMS_REV_LOW && home_case == HMS_CASE_ON_SWITCH && sw_edge && !abort |=> state == HMS_FWD_LOW)
      else $error("switch transition in on-switch case did not turn forward");
   a_rise_stops: assert property (@(posedge clk) disable iff (rst)
      state == HMS_FWD_LOW && sw_rise && !abort |=> !cmd.moving && done)
      else $error("rising edge in forward low did not stop");
   a_limit_turns: assert property (@(posedge clk) disable iff (rst)
      state == HMS_REV_HIGH && lim_sync && !sw_rise && !abort |=> !cmd.reverse && cmd.high ##0
      home_case == HMS_CASE_LIMIT)
      else $error("reverse limit did not turn to forward high");
   a_limit_slow: assert property (@(posedge clk) disable iff (rst)
      state == HMS_FWD_HIGH && sw_rise && !abort |=> state == HMS_FWD_LOW && !cmd.high)
      else $error("rising edge after limit did not slow");
   a_debounce: assert property (@(posedge clk) disable iff (rst)
      $rose(sw_deb) |-> $past(sw_sync, 1) && $past(sw_sync, 2))
      else $error("debounced switch rose without a stable input");
   a_high_speed: assert property (@(posedge clk) disable iff (rst)
      $rose(cmd.high) |-> cmd.speed == $past(high_speed))
      else $error("high phase did not take the configured high speed");
   a_limit_once: assert property (@(posedge clk) disable iff (rst)
      state == HMS_FWD_HIGH && lim_sync && !sw_rise && !abort |=> state == HMS_FWD_HIGH)
      else $error("reverse limit acted outside reverse high");
   a_done_holds: assert property (@(posedge clk) disable iff (rst)
      state == HMS_DONE && !start && !abort |=> done && !cmd.moving)
      else $error("axis moved after homing ended");

   c_case_clear: cover property (@(posedge clk) disable iff (rst)
      home_case == HMS_CASE_CLEAR && $rose(done));
   c_case_switch: cover property (@(posedge clk) disable iff (rst)
      home_case == HMS_CASE_ON_SWITCH && $rose(done));
   c_case_limit: cover property (@(posedge clk) disable iff (rst)
      home_case == HMS_CASE_LIMIT && $rose(done));
   c_abort: cover property (@(posedge clk) disable iff (rst) busy && abort);
endmodule // hms_sequencer

/* dv/hms_axis_model.sv */
`timescale 1ns/1ps
module hms_axis_model
   import hms_pkg::*;
(
   // Clock and command
   input  wire logic clk,
   input  hms_cmd_t  cmd,
   // Position preset
   input  wire logic load,
   input  wire logic [31:0] load_pos,
   // Sensors
   output logic      origin_sw,
   output logic      rev_limit
);
   int pos = 0;
   // High phase steps by two; windows stay far wider than debounce
   always @(posedge clk)
   begin
      if (load)
         pos <= load_pos;
      else if (cmd.moving)
         pos <= pos + (cmd.reverse ? -1 : 1) * (cmd.high ? 2 : 1);
   end
   // Second window gives the limit case its second rising edge
   assign origin_sw = (pos >= 100 && pos <= 150) || (pos >= 200 && pos <= 250);
   assign rev_limit = (pos <= 0);
endmodule // hms_axis_model

/* dv/tb.sv */
`timescale 1ns/1ps
`include "hms_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
   $display("Error %0t: value mismatch", $time); end end
module tb
   import hms_pkg::*;
;
   logic                    clk = 0;
   logic                    rst, start, abort, load, origin_sw, rev_limit, busy, done;
   logic [`HMS_SPEED_W-1:0] high_speed, low_speed, lfsr = 16'h005f;
   int                      load_pos, bad_count = 0, n_compared = 0, cycles = 0;
   hms_cmd_t                cmd, prev = '0, e;
   hms_case_t               home_case;
   hms_cmd_t                exp_q[$];

   always #20 clk = ~clk;

   hms_sequencer uut (.clk(clk), .rst(rst), .start(start), .abort(abort), .high_speed(high_speed),
      .low_speed(low_speed), .origin_sw(origin_sw), .rev_limit(rev_limit), .cmd(cmd),
      .home_case(home_case), .busy(busy), .done(done));
   hms_axis_model axis (.clk(clk), .cmd(cmd), .load(load), .load_pos(load_pos),
      .origin_sw(origin_sw), .rev_limit(rev_limit));

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic push(input logic m, input logic r, input logic h, input logic [15:0] s);
      exp_q.push_back(hms_cmd_t'{m, r, h, s});
   endtask

   task automatic run_case(input int p, input hms_case_t c);
      int n;
      @(negedge clk) load = 1;
      load_pos = p;
      @(negedge clk) load = 0;
      // Switch must settle through debounce before start
      repeat (20) @(negedge clk);
      lfsr = lfsr_next(lfsr);
      high_speed = lfsr | 16'h8000;
      lfsr = lfsr_next(lfsr);
      low_speed = (lfsr & 16'h7fff) | 16'h0001;
      case (c)
         HMS_CASE_CLEAR: begin push(1, 1, 1, high_speed); push(1, 1, 0, low_speed); push(1, 0, 0, low_speed); end
         HMS_CASE_ON_SWITCH: begin push(1, 1, 0, low_speed); push(1, 0, 0, low_speed); end
         default: begin push(1, 1, 1, high_speed); push(1, 0, 1, high_speed); push(1, 0, 0, low_speed); end
      endcase
      push(0, 0, 0, 16'h0000);
      start = 1;
      @(negedge clk) start = 0;
      n = 0;
      while (done !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(home_case, c)
      `CHK(done, 1'b1)
   endtask

   // Abort in reverse high must drop the axis back to idle
   task automatic abort_case();
      @(negedge clk) load = 1;
      load_pos = 300;
      @(negedge clk) load = 0;
      repeat (20) @(negedge clk);
      push(1, 1, 1, high_speed);
      push(0, 0, 0, 16'h0000);
      start = 1;
      @(negedge clk) start = 0;
      repeat (5) @(negedge clk);
      abort = 1;
      @(negedge clk) abort = 0;
      @(negedge clk);
      `CHK(home_case, HMS_CASE_NONE)
      `CHK(done, 1'b0)
      `CHK(busy, 1'b0)
   endtask

   // Watcher: every change of command consumes the oldest note
   always @(negedge clk)
   begin
      if (!rst && cmd !== prev)
      begin
         prev = cmd;
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         if (e.moving)
            `CHK(cmd, e)
         else
            `CHK({cmd.moving, cmd.speed}, {e.moving, e.speed})
         `CHK(busy, e.moving)
      end
   end

   task automatic close_out();
      $display("Compared %0d, errors %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         close_out();
      end
   end

   initial
   begin
      rst = 1;
      start = 0;
      abort = 0;
      load = 0;
      load_pos = 0;
      high_speed = '0;
      low_speed = '0;
      repeat (12) @(negedge clk);
      rst = 0;
      run_case(300, HMS_CASE_CLEAR);
      run_case(125, HMS_CASE_ON_SWITCH);
      run_case(50, HMS_CASE_LIMIT);
      abort_case();
      `CHK(exp_q.size(), 0)
      close_out();
   end
endmodule // tb
